// ===== aafr_pkg.sv
// Constants and carrier types for the alarm flag register bank.
// Assumes an outside comparator and a serial front end that turns frames into register reads.
package aafr_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int unsigned NUM_CH     = 8;
    localparam int unsigned CH_W       = 3;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned CH_PER_REG = 4;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_OVERVIEW   = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_LATCH_LOW4 = 8'h11;
    localparam logic [ADDR_W-1:0] ADDR_LIVE_LOW4  = 8'h12;
    localparam logic [ADDR_W-1:0] ADDR_LATCH_UP4  = 8'h13;
    localparam logic [ADDR_W-1:0] ADDR_LIVE_UP4   = 8'h14;

    // ------------------------------------------------------------
    // Reset and fill values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] FLAGS_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] ABSENT_FILL  = 8'hFF;
    localparam logic [DATA_W-1:0] UNMAPPED_VAL = 8'h00;
    localparam logic [NUM_CH-1:0] VEC_RESET    = 8'h00;
    localparam logic [NUM_CH-1:0] UPPER_MASK   = 8'hF0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // One comparison of a fresh conversion result against both thresholds
    typedef struct packed {
        logic            valid;
        logic [CH_W-1:0] chan;
        logic            above_high;
        logic            below_low;
    } aafr_cmp_t;

    // One register read request from the serial front end
    typedef struct packed {
        logic              rd;
        logic [ADDR_W-1:0] addr;
    } aafr_rd_t;

endpackage

// ===== aafr_flag_cell.sv
// One alarm threshold: its live flag and its latched flag.
// Assumes update and clear come from the bank, synchronous to clk_i.
`timescale 1ns/1ns
module aafr_flag_cell
    import aafr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic update_i,
    input  wire logic cond_i,
    input  wire logic clear_i,
    output logic      live_o,
    output logic      latched_o
);

    logic live_q;
    logic latched_q;
    logic latched_d;

    // Live flag follows the condition of each new comparison only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            live_q <= 1'b0;
        end else if (update_i) begin
            live_q <= cond_i;
        end
    end

    // Set wins over a read clear so an alarm during the read is kept
    always_comb begin
        latched_d = latched_q & ~clear_i;
        if (update_i && cond_i) begin
            latched_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            latched_q <= 1'b0;
        end else begin
            latched_q <= latched_d;
        end
    end

    assign live_o    = live_q;
    assign latched_o = latched_q;

endmodule

// ===== aafr_bank.sv
// Alarm flag register bank: live and latched flags per channel threshold, read-only register view.
// Assumes comparisons and read requests arrive synchronous to clk_i from outside logic.
`timescale 1ns/1ns

// Summary of operation
// R1 - Live flag is 1 while the latest result lies beyond its threshold.
// R2 - Latched flag sets like the live flag and clears only on its read.
// R3 - Each channel has high and low thresholds, four flags per channel.
// R4 - Overview register 10h holds OR of high and low latched flags.
// R5 - Overview bit n reports channel n.
// R6 - Register 11h: ch0 low at bit 7 down to ch3 high at bit 0.
// R7 - Register 12h: live flags, same order as 11h.
// R8 - A flag bit reads 1 for alarm detected, 0 otherwise.
// R9 - All flag bits are read-only and reset to zero.
// R10 - Writes to absent channels in the four-channel variant change nothing.
// R11 - Reads of absent channel bits in the four-channel variant return ones.
// R12 - Host should read flags after the alarm pin signals an event.
// R13 - Offsets 11h to 14h hold all flags, channels 0-3 and 4-7 apart.
// R14 - Register 13h: latched ch4 low at bit 7 down to ch7 high.
// R15 - Register 14h: live ch4 low at bit 7 down to ch7 high.
// R16 - Read captures latched value before clearing; concurrent alarm stays latched.
// R17 - Only the compared channel's flags update; others stay unchanged.
module aafr_bank
    import aafr_pkg::*;
#(
    parameter bit EIGHT_CHAN = 1'b1
)(
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire aafr_cmp_t         cmp_i,
    input  wire aafr_rd_t          rd_i,
    output logic [DATA_W-1:0]      rd_data_o,
    output logic                   rd_valid_o
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    // Two stages so the release never lands near an edge inside the bank
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Pack four channels low then high, first channel at bit 7
    function automatic logic [DATA_W-1:0] pack_group(
        input logic [NUM_CH-1:0] lo,
        input logic [NUM_CH-1:0] hi,
        input int unsigned       base
    );
        logic [DATA_W-1:0] r;
        r = FLAGS_RESET;
        for (int unsigned k = 0; k < CH_PER_REG; k++) begin
            r[7-2*k] = lo[base+k];
            r[6-2*k] = hi[base+k];
        end
        return r;
    endfunction

    // Channel exists in the built variant
    function automatic logic chan_present(input logic [CH_W-1:0] ch);
        return EIGHT_CHAN || (ch < CH_W'(CH_PER_REG));
    endfunction

    // ------------------------------------------------------------
    // Flag storage
    // ------------------------------------------------------------
    logic [NUM_CH-1:0] live_hi;
    logic [NUM_CH-1:0] live_lo;
    logic [NUM_CH-1:0] latch_hi;
    logic [NUM_CH-1:0] latch_lo;
    logic [NUM_CH-1:0] upd;
    logic              clr_low4;
    logic              clr_up4;

    // Only the channel named by a valid comparison is touched
    always_comb begin
        upd = VEC_RESET;
        if (cmp_i.valid && chan_present(cmp_i.chan)) begin // R17 R10
            upd[cmp_i.chan] = 1'b1;
        end
    end

    // Clear strobes fire with the read that captures the data
    assign clr_low4 = rd_i.rd && (rd_i.addr == ADDR_LATCH_LOW4); // R2 R16
    assign clr_up4  = rd_i.rd && (rd_i.addr == ADDR_LATCH_UP4) && EIGHT_CHAN; // R16

    // Two thresholds per channel, each with a live and latched flag
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch // R3
        aafr_flag_cell u_high (
            .clk_i     (clk_i),
            .rst_n_i   (rst_n_q),
            .update_i  (upd[c]),
            .cond_i    (cmp_i.above_high), // R1
            .clear_i   ((c < CH_PER_REG) ? clr_low4 : clr_up4),
            .live_o    (live_hi[c]),
            .latched_o (latch_hi[c])
        );
        aafr_flag_cell u_low (
            .clk_i     (clk_i),
            .rst_n_i   (rst_n_q),
            .update_i  (upd[c]),
            .cond_i    (cmp_i.below_low), // R1
            .clear_i   ((c < CH_PER_REG) ? clr_low4 : clr_up4),
            .live_o    (live_lo[c]),
            .latched_o (latch_lo[c])
        );
    end

    // ------------------------------------------------------------
    // Read view
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rd_view;
    logic [NUM_CH-1:0] overview;

    // Bit n of the overview is channel n
    assign overview = latch_hi | latch_lo; // R4 R5

    // Decode of the read address; the bits are flags, 1 means alarm
    always_comb begin
        rd_view = UNMAPPED_VAL;
        case (rd_i.addr)
            ADDR_OVERVIEW: begin
                rd_view = EIGHT_CHAN ? overview : (overview | UPPER_MASK); // R4 R11
            end
            ADDR_LATCH_LOW4: begin
                rd_view = pack_group(latch_lo, latch_hi, 0); // R6 R8
            end
            ADDR_LIVE_LOW4: begin
                rd_view = pack_group(live_lo, live_hi, 0); // R7 R8
            end
            ADDR_LATCH_UP4: begin
                rd_view = EIGHT_CHAN ? pack_group(latch_lo, latch_hi, CH_PER_REG) : ABSENT_FILL; // R14 R11
            end
            ADDR_LIVE_UP4: begin
                rd_view = EIGHT_CHAN ? pack_group(live_lo, live_hi, CH_PER_REG) : ABSENT_FILL; // R15 R11
            end
            default: begin
                rd_view = UNMAPPED_VAL;
            end
        endcase
    end

    // Capture happens on the same edge as the clear, so nothing is lost
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rd_data_o <= FLAGS_RESET; // R9
        end else if (rd_i.rd) begin
            rd_data_o <= rd_view; // R16 R13
        end
    end

    // Answer strobe one cycle after the request
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_i.rd;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_live_follow: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R1
        (cmp_i.valid && chan_present(cmp_i.chan))
        |=> (live_hi[$past(cmp_i.chan)] == $past(cmp_i.above_high))
         && (live_lo[$past(cmp_i.chan)] == $past(cmp_i.below_low)))
        else $error("live flag does not follow comparison");

    a_others_unchanged: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R17
        (!cmp_i.valid) |=> $stable(live_hi) && $stable(live_lo))
        else $error("live flags changed without a comparison");

    // Set is visible in the next cycle even when a clearing read coincides
    a_latch_set: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R2
        (cmp_i.valid && chan_present(cmp_i.chan) && cmp_i.above_high)
        |=> latch_hi[$past(cmp_i.chan)])
        else $error("latched high flag not set");

    a_latch_set_low: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R2
        (cmp_i.valid && chan_present(cmp_i.chan) && cmp_i.below_low)
        |=> latch_lo[$past(cmp_i.chan)])
        else $error("latched low flag not set");

    a_latch_hold: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R2
        (!rd_i.rd) |=> ((latch_hi & $past(latch_hi)) == $past(latch_hi))
                    && ((latch_lo & $past(latch_lo)) == $past(latch_lo)))
        else $error("latched flag dropped without a read");

    a_read_clears: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R2
        (clr_low4 && !cmp_i.valid) |=> (latch_hi[3:0] == 4'h0) && (latch_lo[3:0] == 4'h0))
        else $error("read did not clear latched flags");

    a_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R16
        (clr_low4 && cmp_i.valid && (cmp_i.chan == 3'h1) && cmp_i.below_low)
        |=> latch_lo[1] && (rd_data_o[5] == $past(latch_lo[1])))
        else $error("alarm during read was lost");

    a_overview_or: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R4 R5
        (rd_i.rd && (rd_i.addr == ADDR_OVERVIEW))
        |=> rd_valid_o && (rd_data_o[0] == ($past(latch_hi[0]) | $past(latch_lo[0])))
         && (rd_data_o[3] == ($past(latch_hi[3]) | $past(latch_lo[3]))))
        else $error("overview bit is not OR of channel flags");

    a_map_latch0: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R6
        (rd_i.rd && (rd_i.addr == ADDR_LATCH_LOW4))
        |=> (rd_data_o[7] == $past(latch_lo[0])) && (rd_data_o[6] == $past(latch_hi[0]))
         && (rd_data_o[0] == $past(latch_hi[3])))
        else $error("latched register 11h bit order wrong");

    a_map_live0: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R7
        (rd_i.rd && (rd_i.addr == ADDR_LIVE_LOW4))
        |=> (rd_data_o[5] == $past(live_lo[1])) && (rd_data_o[2] == $past(live_hi[2])))
        else $error("live register 12h bit order wrong");

    a_map_upper: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R15
        (EIGHT_CHAN && rd_i.rd && (rd_i.addr == ADDR_LIVE_UP4))
        |=> (rd_data_o[7] == $past(live_lo[4])) && (rd_data_o[0] == $past(live_hi[7])))
        else $error("upper live register bit order wrong");

    a_absent_ones: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R11
        (!EIGHT_CHAN && rd_i.rd && ((rd_i.addr == ADDR_LATCH_UP4) || (rd_i.addr == ADDR_LIVE_UP4)))
        |=> (rd_data_o == ABSENT_FILL))
        else $error("absent channel read not all ones");

    a_absent_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R10
        1'b1 |-> (EIGHT_CHAN || ((latch_hi[7:4] == 4'h0) && (live_lo[7:4] == 4'h0))))
        else $error("absent channel flag became set");

    // Channels not named by the comparison keep their live flags and set no latched flag
    a_other_chan_hold: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R17
        cmp_i.valid
        |=> (((live_hi ^ $past(live_hi)) & ~$past(upd)) == VEC_RESET)
         && (((live_lo ^ $past(live_lo)) & ~$past(upd)) == VEC_RESET))
        else $error("live flag of an uncompared channel changed");

    a_other_latch_hold: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R17
        1'b1
        |=> ((latch_hi & ~$past(latch_hi) & ~$past(upd)) == VEC_RESET)
         && ((latch_lo & ~$past(latch_lo) & ~$past(upd)) == VEC_RESET))
        else $error("latched flag of an uncompared channel set");

    // Read port timing: one answer strobe per read, data held between reads
    a_valid_answer: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R13
        rd_i.rd |=> rd_valid_o)
        else $error("read not answered in the next cycle");

    a_valid_idle: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R13
        (!rd_i.rd) |=> !rd_valid_o)
        else $error("answer strobe without a read");

    a_data_hold: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R16
        (!rd_i.rd) |=> $stable(rd_data_o))
        else $error("read data changed without a read");

    a_unmapped_zero: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R13
        (rd_i.rd && ((rd_i.addr < ADDR_OVERVIEW) || (rd_i.addr > ADDR_LIVE_UP4)))
        |=> (rd_data_o == UNMAPPED_VAL))
        else $error("unmapped offset did not read zero");

    a_map_latch_up: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R14
        (EIGHT_CHAN && rd_i.rd && (rd_i.addr == ADDR_LATCH_UP4))
        |=> (rd_data_o[7] == $past(latch_lo[4])) && (rd_data_o[0] == $past(latch_hi[7])))
        else $error("upper latched register bit order wrong");

    a_absent_overview: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R11
        (!EIGHT_CHAN && rd_i.rd && (rd_i.addr == ADDR_OVERVIEW))
        |=> (rd_data_o[7:4] == 4'hF))
        else $error("absent overview bits not all ones");

    a_up_read_clears: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R2
        (clr_up4 && !cmp_i.valid)
        |=> (latch_hi[7:4] == 4'h0) && (latch_lo[7:4] == 4'h0))
        else $error("upper read did not clear latched flags");

    // Overview and live reads must leave the latched flags alone
    a_view_keeps_latch: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R2
        (rd_i.rd && (rd_i.addr != ADDR_LATCH_LOW4) && (rd_i.addr != ADDR_LATCH_UP4))
        |=> ((latch_hi & $past(latch_hi)) == $past(latch_hi))
         && ((latch_lo & $past(latch_lo)) == $past(latch_lo)))
        else $error("non-clearing read dropped a latched flag");

    // Held in reset, every flag and the read port stay at zero
    a_reset_clear: assert property (@(posedge clk_i) // R9
        (!rst_n_q)
        |-> (rd_data_o == FLAGS_RESET) && !rd_valid_o && (latch_hi == VEC_RESET)
         && (latch_lo == VEC_RESET) && (live_hi == VEC_RESET) && (live_lo == VEC_RESET))
        else $error("flags not zero during reset");

    a_overview_all: assert property (@(posedge clk_i) disable iff (!rst_n_q) // R4 R5
        (EIGHT_CHAN && rd_i.rd && (rd_i.addr == ADDR_OVERVIEW))
        |=> (rd_data_o == ($past(latch_hi) | $past(latch_lo))))
        else $error("overview register is not OR of all channels");

endmodule

// ===== aafr_host_model.sv
// Host model: reads flag registers through the bank's parallel read strobe.
// Assumes the bank answers in the cycle after the edge that takes the strobe.
`timescale 1ns/1ns
module aafr_host_model
    import aafr_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic [DATA_W-1:0] rd_data_i,
    input  wire logic              rd_valid_i,
    output aafr_rd_t               rd_o
);
    // ------------------------------------------------------------
    // Read strobe
    // ------------------------------------------------------------
    // Idle until the bench asks for a read
    initial rd_o = '0;

    // One read; the caller reads at any time, with or without a prior alarm event
    task automatic read_reg(input logic [ADDR_W-1:0] addr,
                            output logic [DATA_W-1:0] data,
                            output logic ok);
        @(negedge clk_i);
        rd_o = {1'b1, addr};
        @(negedge clk_i);
        // Answer sampled mid-cycle, once the taking edge has settled
        ok = rd_valid_i;
        data = rd_data_i;
        rd_o = {1'b0, ~addr}; // Stale address hidden after release
    endtask
endmodule

// ===== adc_alarm_flag_registers_tb.sv
// Self-checking bench for the alarm flag bank, eight- and four-channel builds side by side.
// Assumes aafr_pkg, aafr_bank and aafr_host_model are compiled first.
`timescale 1ns/1ns
module adc_alarm_flag_registers_tb;
    import aafr_pkg::*;
    logic              clk_i;
    logic              reset_n_i;
    aafr_cmp_t         cmp8;
    aafr_cmp_t         cmp4;
    aafr_rd_t          rd8;
    aafr_rd_t          rd4;
    logic [DATA_W-1:0] data8;
    logic [DATA_W-1:0] data4;
    logic              vld8;
    logic              vld4;
    int                bad_count;
    int                tests_run;
    int                cycles;

    // ------------------------------------------------------------
    // Benches and hosts
    // ------------------------------------------------------------
    aafr_bank #(.EIGHT_CHAN(1'b1)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .cmp_i(cmp8), .rd_i(rd8),
        .rd_data_o(data8), .rd_valid_o(vld8));
    aafr_bank #(.EIGHT_CHAN(1'b0)) dut4 (.clk_i(clk_i), .reset_n_i(reset_n_i), .cmp_i(cmp4), .rd_i(rd4),
        .rd_data_o(data4), .rd_valid_o(vld4));
    aafr_host_model host8 (.clk_i(clk_i), .rd_data_i(data8), .rd_valid_i(vld8), .rd_o(rd8));
    aafr_host_model host4 (.clk_i(clk_i), .rd_data_i(data4), .rd_valid_i(vld4), .rd_o(rd4));

    // 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Read through one host, answer must come back valid
    task automatic rd(input bit four, input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        if (four) host4.read_reg(addr, d, v);
        else host8.read_reg(addr, d, v);
        check({7'h00, v}, 8'h01);
        check(d, exp);
    endtask

    // One comparison pulse, then idle
    task automatic cmp(input bit four, input int ch, input bit hi, input bit lo);
        aafr_cmp_t c;
        c = {1'b1, 3'(ch), hi, lo};
        @(negedge clk_i);
        if (four) cmp4 = c;
        else cmp8 = c;
        @(negedge clk_i);
        cmp4 = '0;
        cmp8 = '0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Every flag register plus one unmapped offset reads zero after reset
    task automatic reset_values();
        for (int i = 0; i < 6; i++) begin
            rd(1'b0, ADDR_OVERVIEW + 8'(i), 8'h00);
        end
        rd(1'b1, ADDR_LATCH_LOW4, 8'h00);
    endtask

    // One threshold of one channel: live follows, latch sticks until read
    task automatic alarm_walk(input int ch, input bit hi);
        logic [7:0] b;
        logic [7:0] lat;
        logic [7:0] live;
        b = 8'h80 >> (2 * (ch % 4) + int'(hi));
        lat = (ch < 4) ? ADDR_LATCH_LOW4 : ADDR_LATCH_UP4;
        live = (ch < 4) ? ADDR_LIVE_LOW4 : ADDR_LIVE_UP4;
        cmp(1'b0, ch, hi, !hi);
        rd(1'b0, live, b);
        rd(1'b0, ADDR_OVERVIEW, 8'h01 << ch);
        rd(1'b0, lat, b);
        rd(1'b0, lat, 8'h00);
        rd(1'b0, ADDR_OVERVIEW, 8'h00);
        rd(1'b0, live, b);
        cmp(1'b0, ch, 1'b0, 1'b0);
        rd(1'b0, live, 8'h00);
    endtask

    // Alarm in the very cycle of a latched read must survive it
    task automatic read_race();
        logic [7:0] d;
        logic       v;
        cmp(1'b0, 0, 1'b1, 1'b0);
        fork
            host8.read_reg(ADDR_LATCH_LOW4, d, v);
            begin
                @(negedge clk_i);
                cmp8 = {1'b1, 3'd1, 1'b0, 1'b1};
                @(negedge clk_i);
                cmp8 = '0;
            end
        join
        check(d, 8'h40);
        check({7'h00, v}, 8'h01);
        rd(1'b0, ADDR_LATCH_LOW4, 8'h20);
        rd(1'b0, ADDR_LIVE_LOW4, 8'h60);
    endtask

    // Four-channel build: absent channels read ones and ignore comparisons
    task automatic four_chan();
        rd(1'b1, ADDR_LATCH_UP4, 8'hFF);
        rd(1'b1, ADDR_LIVE_UP4, 8'hFF);
        cmp(1'b1, 5, 1'b1, 1'b1);
        rd(1'b1, ADDR_OVERVIEW, 8'hF0);
        cmp(1'b1, 2, 1'b0, 1'b1);
        rd(1'b1, ADDR_OVERVIEW, 8'hF4);
        rd(1'b1, ADDR_LATCH_UP4, 8'hFF);
        rd(1'b1, ADDR_LATCH_LOW4, 8'h08);
        rd(1'b1, ADDR_OVERVIEW, 8'hF0);
    endtask

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        cmp8 = '0;
        cmp4 = '0;
        reset_n_i = 1'b0;
        bad_count = 0;
        tests_run = 0;
        cycles = 0;
        repeat (3) @(negedge clk_i);
        reset_n_i = 1'b1;
        // Internal reset lifts two edges later
        repeat (3) @(negedge clk_i);
        reset_values();
        for (int ch = 0; ch < 8; ch++) begin
            alarm_walk(ch, 1'b1);
            alarm_walk(ch, 1'b0);
        end
        read_race();
        four_chan();
        end_of_test();
    end
endmodule
